// ==== rtl/mpcr_defines.vh ====
/*
 holds register offsets, field positions, reset values and encodings
 of the master port configuration register bank.
 assumes inclusion by bare name from the rtl files.
*/
`ifndef MPCR_DEFINES_VH
`define MPCR_DEFINES_VH

`define MPCR_ADDR_W 12
`define MPCR_OFF_CLK_MODE 12'h020
`define MPCR_OFF_MERGE_BYP 12'h024
`define MPCR_OFF_LONG_BURST 12'h02c
`define MPCR_OFF_WR_MARK 12'h040
`define MPCR_OFF_HOST_CTRL 12'h044
`define MPCR_OFF_ISSUE_OVR 12'h108

`define MPCR_CLK_MODE_W 3
`define MPCR_CLK_MODE_RST 3'h4
`define MPCR_CLK_SYNC_1_1 3'h0
`define MPCR_CLK_SYNC_M_1 3'h1
`define MPCR_CLK_SYNC_1_N 3'h2
`define MPCR_CLK_SYNC_M_N 3'h3
`define MPCR_CLK_ASYNC 3'h4

`define MPCR_MERGE_BYP_RST 1'h0
`define MPCR_LONG_BURST_RST 1'h0
`define MPCR_WR_MARK_W 4
`define MPCR_HOST_CTRL_W 2
`define MPCR_HOST_CTRL_RST 2'h0
`define MPCR_HOST_DECERR_BIT 0
`define MPCR_HOST_INCR_BIT 1
`define MPCR_ISSUE_OVR_W 2
`define MPCR_ISSUE_OVR_RST 2'h0
`define MPCR_ISSUE_RD_BIT 0
`define MPCR_ISSUE_WR_BIT 1

`endif

// ==== rtl/mpcr_apb_decode.v ====
/*
 apb address decoder for the config bank: one-hot register select.
 assumes word-aligned byte addresses; presence flags come from the top.
*/
`timescale 1ns/100ps
`include "mpcr_defines.vh"

module mpcr_apb_decode #(
  parameter HAS_CLK_MODE = 1,
  parameter HAS_MERGE = 1,
  parameter HAS_LONG_BURST = 1,
  parameter HAS_WR_MARK = 1,
  parameter HAS_HOST = 1,
  parameter HAS_ISSUE = 1
) (
  input wire [`MPCR_ADDR_W-1:0] paddr,
  output reg [5:0] sel
);
  // absent registers never select, so they act as reserved
  always @* begin
    sel = 6'h00;
    case (paddr)
      `MPCR_OFF_CLK_MODE: sel[0] = (HAS_CLK_MODE != 0);
      `MPCR_OFF_MERGE_BYP: sel[1] = (HAS_MERGE != 0);
      `MPCR_OFF_LONG_BURST: sel[2] = (HAS_LONG_BURST != 0);
      `MPCR_OFF_WR_MARK: sel[3] = (HAS_WR_MARK != 0);
      `MPCR_OFF_HOST_CTRL: sel[4] = (HAS_HOST != 0);
      `MPCR_OFF_ISSUE_OVR: sel[5] = (HAS_ISSUE != 0);
      default: sel = 6'h00;
    endcase
  end
endmodule // mpcr_apb_decode

// ==== rtl/mpcr_regs.v ====
/*
 master port configuration register bank behind an apb slave.
 assumes pclk-domain apb master on clk; outputs feed the port datapath.
*/
// Local design decision: the APB register port.
// What this block does
// - clock mode is 3-bit rw: 0..3 sync variants, 4 async, 5-7 reserved
// - clock mode exists only if programmable; resets to async (4)
// - merge bypass is one rw bit, reset 0, only when resizing width
// - long burst bit 0 forbids long output bursts, 1 allows them
// - long burst bit exists only when downsizing to axi4; rw, reset 0
// - without programmability the long burst default holds: none emitted
// - 4-bit write fifo mark only takes effect with a nonzero-mark fifo
// - write fifo mark resets to the generation-time configured level
// - host bus control: 2 rw bits, reset 0; bit0 decode err, bit1 incr
// - issue override bits: bit0 forces read, bit1 write issuing to one
// - issue override exists only when resizing or any channel has fifo
`timescale 1ns/100ps
`include "mpcr_defines.vh"

module mpcr_regs #(
  parameter PROGRAMMABLE = 1,
  parameter CLK_MODE_PROG = 1,
  parameter RESIZING = 1,
  parameter DOWNSIZE_AXI4 = 1,
  parameter WRITE_DATA_FIFO_PRESENT = 1,
  parameter [`MPCR_WR_MARK_W-1:0] WR_MARK_CFG = 4'h8,
  parameter HOST_PORT = 1,
  parameter ANY_FIFO = 1
) (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`MPCR_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg [`MPCR_CLK_MODE_W-1:0] clk_mode,
  output reg merge_bypass,
  output reg long_burst_en,
  output reg wr_mark_en,
  output reg [`MPCR_WR_MARK_W-1:0] wr_mark_level,
  output reg decerr_en,
  output reg force_incr,
  output reg rd_issue_one,
  output reg wr_issue_one
);
  localparam HAS_CLK = (PROGRAMMABLE != 0) && (CLK_MODE_PROG != 0);
  localparam HAS_MERGE = (PROGRAMMABLE != 0) && (RESIZING != 0);
  localparam HAS_LB = (PROGRAMMABLE != 0) && (DOWNSIZE_AXI4 != 0);
  localparam MARK_LIVE = (WRITE_DATA_FIFO_PRESENT != 0) && (WR_MARK_CFG != 4'h0);
  localparam HAS_MARK = (PROGRAMMABLE != 0) && MARK_LIVE;
  localparam HAS_HOST = (PROGRAMMABLE != 0) && (HOST_PORT != 0);
  localparam HAS_ISS = (PROGRAMMABLE != 0) &&
    ((RESIZING != 0) || (ANY_FIFO != 0));

  localparam ST_IDLE = 2'b01;
  localparam ST_DONE = 2'b10;

  reg [1:0] state_r;
  reg [`MPCR_CLK_MODE_W-1:0] clk_mode_r;
  reg merge_r;
  reg long_burst_r;
  reg [`MPCR_WR_MARK_W-1:0] mark_r;
  reg [`MPCR_HOST_CTRL_W-1:0] host_r;
  reg [`MPCR_ISSUE_OVR_W-1:0] issue_r;
  reg [31:0] rdata_nxt;
  wire [5:0] sel;
  wire acc;
  wire wr;

  mpcr_apb_decode #(
    .HAS_CLK_MODE(HAS_CLK),
    .HAS_MERGE(HAS_MERGE),
    .HAS_LONG_BURST(HAS_LB),
    .HAS_WR_MARK(HAS_MARK),
    .HAS_HOST(HAS_HOST),
    .HAS_ISSUE(HAS_ISS)
  ) u_dec (
    .paddr(paddr),
    .sel(sel)
  );

  // one wait state: answer in the cycle after the first access cycle
  assign acc = psel & penable & (state_r == ST_IDLE);
  assign wr = acc & pwrite;

  // zero-extended pad helper for the read mux
  function [31:0] pad;
    input [3:0] v;
    begin
      pad = {28'h0000000, v};
    end
  endfunction

  always @* begin
    rdata_nxt = 32'h00000000;
    case (1'b1)
      sel[0]: rdata_nxt = pad({1'b0, clk_mode_r});
      sel[1]: rdata_nxt = pad({3'h0, merge_r});
      sel[2]: rdata_nxt = pad({3'h0, long_burst_r});
      sel[3]: rdata_nxt = pad(mark_r);
      sel[4]: rdata_nxt = pad({2'h0, host_r});
      sel[5]: rdata_nxt = pad({2'h0, issue_r});
      default: rdata_nxt = 32'h00000000;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (acc) begin
            state_r <= ST_DONE;
            pready <= 1'b1;
            prdata <= pwrite ? 32'h00000000 : rdata_nxt;
          end
        end
        ST_DONE: begin
          state_r <= ST_IDLE;
          pready <= 1'b0;
          prdata <= 32'h00000000;
        end
        default: begin
          state_r <= ST_IDLE;
          pready <= 1'b0;
        end
      endcase
    end
  end

  // writes land at the taking edge; absent registers keep their reset
  always @(posedge clk) begin
    if (!rst_n) begin
      clk_mode_r <= `MPCR_CLK_MODE_RST;
      merge_r <= `MPCR_MERGE_BYP_RST;
      long_burst_r <= `MPCR_LONG_BURST_RST;
      mark_r <= WR_MARK_CFG;
      host_r <= `MPCR_HOST_CTRL_RST;
      issue_r <= `MPCR_ISSUE_OVR_RST;
    end else begin
      if (wr && sel[0])
        clk_mode_r <= pwdata[`MPCR_CLK_MODE_W-1:0];
      if (wr && sel[1])
        merge_r <= pwdata[0];
      if (wr && sel[2])
        long_burst_r <= pwdata[0];
      if (wr && sel[3])
        mark_r <= pwdata[`MPCR_WR_MARK_W-1:0];
      if (wr && sel[4])
        host_r <= pwdata[`MPCR_HOST_CTRL_W-1:0];
      if (wr && sel[5])
        issue_r <= pwdata[`MPCR_ISSUE_OVR_W-1:0];
    end
  end

  // registered outputs; reserved clock codes pass as written, the
  // datapath owns their meaning
  always @(posedge clk) begin
    if (!rst_n) begin
      clk_mode <= `MPCR_CLK_MODE_RST;
      merge_bypass <= 1'b0;
      long_burst_en <= 1'b0;
      wr_mark_en <= 1'b0;
      wr_mark_level <= {`MPCR_WR_MARK_W{1'b0}};
      decerr_en <= 1'b0;
      force_incr <= 1'b0;
      rd_issue_one <= 1'b0;
      wr_issue_one <= 1'b0;
    end else begin
      clk_mode <= clk_mode_r;
      merge_bypass <= merge_r;
      long_burst_en <= long_burst_r & (HAS_LB != 0);
      wr_mark_en <= MARK_LIVE;
      wr_mark_level <= mark_r;
      decerr_en <= host_r[`MPCR_HOST_DECERR_BIT];
      force_incr <= host_r[`MPCR_HOST_INCR_BIT];
      rd_issue_one <= issue_r[`MPCR_ISSUE_RD_BIT];
      wr_issue_one <= issue_r[`MPCR_ISSUE_WR_BIT];
    end
  end
endmodule // mpcr_regs

// ==== bench/mpcr_checker.sv ====
/* port assertions for the config register bank.
 assumes binding to mpcr_regs, apb on clk. */
`timescale 1ns/100ps
module mpcr_checker #(
  parameter [3:0] WR_MARK_CFG = 4'h8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic [2:0] clk_mode,
  input wire logic merge_bypass,
  input wire logic long_burst_en,
  input wire logic wr_mark_en,
  input wire logic [3:0] wr_mark_level,
  input wire logic decerr_en,
  input wire logic force_incr,
  input wire logic rd_issue_one,
  input wire logic wr_issue_one
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [31:0] wd_r;
  wire done = psel && penable && pready;
  wire wr = done && pwrite;
  wire rsv = !(paddr inside {12'h020, 12'h024, 12'h02c, 12'h040, 12'h044,
    12'h108});
  // holds the completed write word for the one-clock output lag
  always @(posedge clk) wd_r <= pwdata;
  a_reset_values: assert property ($rose(rst_n) |-> clk_mode == 3'h4 &&
    {merge_bypass, long_burst_en, decerr_en, force_incr, rd_issue_one,
    wr_issue_one} == 6'h0) else $error("bad reset value");
  a_mark_reset: assert property ($rose(rst_n) |=>
    wr_mark_level == WR_MARK_CFG && wr_mark_en) else $error("bad mark reset");
  a_mode_write: assert property (wr && paddr == 12'h020 |=>
    clk_mode == wd_r[2:0]) else $error("clock mode not written");
  a_merge_write: assert property (wr && paddr == 12'h024 |=>
    merge_bypass == wd_r[0]) else $error("merge bit not written");
  a_burst_write: assert property (wr && paddr == 12'h02c |=>
    long_burst_en == wd_r[0]) else $error("burst bit not written");
  a_mark_write: assert property (wr && paddr == 12'h040 |=>
    wr_mark_level == wd_r[3:0]) else $error("mark not written");
  a_host_write: assert property (wr && paddr == 12'h044 |=>
    {force_incr, decerr_en} == wd_r[1:0]) else $error("host bits wrong");
  a_issue_write: assert property (wr && paddr == 12'h108 |=>
    {wr_issue_one, rd_issue_one} == wd_r[1:0]) else $error("issue bits wrong");
  a_reserved_zero: assert property (done && !pwrite && rsv |->
    prdata == 32'h0) else $error("reserved read not zero");
  a_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after one wait");
  cover property (wr && paddr == 12'h020 && pwdata[2:0] == 3'h7);
  cover property (done && rsv);
  cover property (wr && paddr == 12'h108);
endmodule // mpcr_checker
bind mpcr_regs mpcr_checker #(.WR_MARK_CFG(WR_MARK_CFG)) u_chk (.clk, .rst_n,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .clk_mode,
  .merge_bypass, .long_burst_en, .wr_mark_en, .wr_mark_level, .decerr_en,
  .force_incr, .rd_issue_one, .wr_issue_one);

// ==== bench/test_master_port_config_regs.sv ====
/* self-checking bench for the config bank, model in arrays.
 assumes default generation parameters, mark level 8. */
`timescale 1ns/100ps
module test_master_port_config_regs;
  logic clk, rst_n, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire pready, pslverr, merge_bypass, long_burst_en, wr_mark_en;
  wire decerr_en, force_incr, rd_issue_one, wr_issue_one;
  wire [2:0] clk_mode;
  wire [3:0] wr_mark_level;
  integer miscompares = 0, total_checks = 0, seed = 32'h0945f5a5, i, k;
  logic [11:0] offs [0:5] = '{12'h020, 12'h024, 12'h02c, 12'h040, 12'h044,
    12'h108};
  logic [11:0] rsv [0:3] = '{12'h000, 12'h028, 12'h10c, 12'hffc};
  logic [31:0] msk [0:5] = '{32'h7, 32'h1, 32'h1, 32'hf, 32'h3, 32'h3};
  logic [31:0] rstv [0:5] = '{32'h4, 32'h0, 32'h0, 32'h8, 32'h0, 32'h0};
  logic [31:0] m [0:5];
  mpcr_regs DUT (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .clk_mode, .merge_bypass, .long_burst_en,
    .wr_mark_en, .wr_mark_level, .decerr_en, .force_incr, .rd_issue_one,
    .wr_issue_one);
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task chk(input [31:0] got, input [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // waits for pready however long it takes; only the watchdog ends a hang
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    chk(pslverr, 0);
    psel <= 0; penable <= 0;
  endtask
  task outs;
    @(posedge clk); #1;
    chk({clk_mode, merge_bypass, long_burst_en, wr_mark_level, force_incr,
      decerr_en, wr_issue_one, rd_issue_one}, {m[0][2:0], m[1][0], m[2][0],
      m[3][3:0], m[4][1:0], m[5][1:0]});
  endtask
  task do_reset;
    @(posedge clk);
    rst_n <= 0;
    repeat (12) @(posedge clk);
    rst_n <= 1;
    for (k = 0; k < 6; k++) m[k] = rstv[k];
    outs;
    chk(wr_mark_en, 1);
  endtask
  task wr_rd(input [11:0] a, input [31:0] d, input integer j);
    apb(1, a, d);
    if (j >= 0) m[j] = d & msk[j];
    apb(0, a, 0);
    chk(rd, j >= 0 ? m[j] : 0);
    outs;
  endtask
  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; rst_n = 0;
    do_reset;
    for (i = 0; i < 6; i++) begin
      apb(0, offs[i], 0);
      chk(rd, rstv[i]);
    end
    for (i = 0; i < 8; i++) wr_rd(12'h020, i, 0);
    for (i = 0; i < 40; i++) begin
      k = $unsigned($random(seed)) % 10;
      if (k < 6) wr_rd(offs[k], $random(seed), k);
      else wr_rd(rsv[k - 6], $random(seed), -1);
    end
    do_reset;
    for (i = 0; i < 6; i++) begin
      apb(0, offs[i], 0);
      chk(rd, rstv[i]);
    end
    wrap_up;
  end
  initial begin
    #20000;
    miscompares++;
    wrap_up;
  end
endmodule // test_master_port_config_regs
